/* File: logic/fll_consts.svh */
`ifndef FLL_CONSTS_SVH
`define FLL_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define OFF_CTRL_ONE 8'h9B
`define OFF_DIV_CTRL 8'h9C
`define OFF_RATIO_CTRL 8'h9D
`define OFF_RSVD_CTRL 8'h9E
`define OFF_NUMER 8'hA0
`define OFF_DENOM 8'hA1
`define OFF_INTMUL 8'hA2
`define OFF_REF_SRC 8'hA3
`define OFF_STATUS 8'hA4

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ENA_BIT 0
`define FRAC_BIT 2
`define RSV1_BIT 3
`define OUTDIV_LSB 3
`define OUTDIV_MSB 8
`define PREDIV_MSB 1
`define RSV3_LSB 4
`define RSV3_MSB 8
`define FRATIO_MSB 2
`define RSV4_MSB 3

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RST_ENA 1'h0
`define RST_FRAC 1'h1
`define RST_RSV1 1'h1
`define RST_OUTDIV 6'h07
`define RST_PREDIV 2'h1
`define RST_RSV3 5'h18
`define RST_FRATIO 3'h0
`define RST_RSV4 4'h0
`define RST_NUMER 16'h0018
`define RST_DENOM 16'h007D
`define RST_INTMUL 10'h008
`define RST_REF_SRC 2'h0

`endif

/* File: logic/fll_pkg.sv */
package fll_pkg;

  // Reference source codes; code 3 falls back to the oscillator
  typedef enum logic [1:0] {
    SRC_MASTER = 2'b00,
    SRC_BIT = 2'b01,
    SRC_OSC = 2'b10
  } ref_src_t;

  // Enable sequencing of the output clock
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ARM = 2'b01,
    ST_RUN = 2'b10
  } run_state_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  // Settings handed to the analogue loop
  typedef struct packed {
    logic enable;
    logic fractional;
    logic [9:0] n;
    logic [15:0] theta;
    logic [15:0] lambda;
    logic [4:0] vco_mult;
  } loop_cfg_t;

  // VCO ratio code to multiplier; any code with bit 2 set gives 16
  function automatic logic [4:0] decode_vco_ratio(input logic [2:0] c);
    logic [4:0] m;
    m = 5'h10;
    case (c)
      3'h0: m = 5'h01;
      3'h1: m = 5'h02;
      3'h2: m = 5'h04;
      3'h3: m = 5'h08;
      default: m = 5'h10;
    endcase
    return m;
  endfunction : decode_vco_ratio

endpackage : fll_pkg

/* File: logic/ref_prediv.sv */
`timescale 1ns/1ps

module ref_prediv (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic run, // Loop enabled
  input wire logic ref_edge, // Rising edge of selected reference
  input wire logic [1:0] code, // Pre-divide code
  output logic tick // One pulse per divided period
);

  logic [1:0] cnt_reg;
  logic [1:0] last;

  // ----------------------------------------
  // Edge counter
  // ----------------------------------------
  // Reserved code 3 is served as divide by four
  always_comb begin
    case (code)
      2'h0: last = 2'h0;
      2'h1: last = 2'h1;
      default: last = 2'h3;
    endcase
  end

  // Counter clears while stopped so each start is phase aligned
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt_reg <= 2'h0;
      tick <= 1'b0;
    end else begin
      tick <= ref_edge && (cnt_reg >= last);
      if (ref_edge) begin
        cnt_reg <= (cnt_reg >= last) ? 2'h0 : cnt_reg + 2'h1;
      end
    end
  end

endmodule : ref_prediv

/* File: logic/out_divider.sv */
`timescale 1ns/1ps

module out_divider #(
  parameter int W = 6 // Ratio code width
) (
  input wire logic clk, // System clock
  input wire logic reset, // Synchronous reset
  input wire logic run, // Output allowed
  input wire logic vco_tick, // One pulse per VCO period
  input wire logic [W-1:0] code, // Ratio code, ratio is code+1
  output logic clk_out // Divided output clock
);

  generate
    if (W < 2) begin : g_bad
      $error("out_divider needs W of at least 2");
    end
  endgenerate

  logic [W-1:0] cnt_reg;
  logic [W-1:0] cur_reg;
  logic [W-1:0] eff;
  logic [W:0] half;
  logic [W:0] cnt_inc;

  // ----------------------------------------
  // Period counter
  // ----------------------------------------
  // Reserved code 0 is served as ratio 2
  assign eff = (code == '0) ? W'(1) : code;
  assign half = ({1'b0, cur_reg} + (W+1)'(1)) >> 1;
  assign cnt_inc = {1'b0, cnt_reg} + (W+1)'(1);

  // Ratio is taken only at a period boundary, so a change never cuts a
  // pulse short; stopped state parks the counter at the wrap point
  always_ff @(posedge clk) begin
    if (reset || !run) begin
      cnt_reg <= eff;
      cur_reg <= eff;
      clk_out <= 1'b0;
    end else if (vco_tick) begin
      if (cnt_reg == cur_reg) begin
        cnt_reg <= '0;
        cur_reg <= eff;
        clk_out <= 1'b1;
      end else begin
        cnt_reg <= cnt_inc[W-1:0];
        clk_out <= (cnt_inc < half);
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence wrap_s;
    run && vco_tick && (cnt_reg == cur_reg);
  endsequence

  period_start_a: assert property (@(posedge clk) disable iff (reset)
    wrap_s |=> clk_out && (cnt_reg == '0))
    else $error("output period did not start high");

  stop_low_a: assert property (@(posedge clk) disable iff (reset)
    !run |=> !clk_out ##0 (cnt_reg == cur_reg))
    else $error("output not parked low when stopped");

endmodule : out_divider

/* File: logic/fll_clock_synthesis_control.sv */
`timescale 1ns/1ps
`include "fll_consts.svh"

module fll_clock_synthesis_control #(
  parameter int OUT_W = 6, // Output ratio code width
  parameter int N_W = 10 // Integer multiplier width
) (
  input wire logic clk, // System clock, 25 MHz
  input wire logic reset, // Synchronous reset, active high
  input wire fll_pkg::bus_req_t bus, // Register port request
  input wire logic master_clk_in, // Master clock reference level
  input wire logic bit_clk_in, // Bit clock reference level
  input wire logic osc_clk_in, // Internal oscillator level
  input wire logic vco_tick, // One pulse per VCO period
  output logic [15:0] rdata, // Read data, cycle after strobe
  output fll_pkg::loop_cfg_t loop_cfg, // Settings to analogue loop
  output logic ref_tick, // Divided reference pulse
  output logic system_clock // Synthesised system clock
);
  import fll_pkg::*;

  generate
    if (OUT_W != 6 || N_W != 10) begin : g_bad
      $error("field widths are fixed by the register map");
    end
  endgenerate

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic ena_reg;
  logic frac_reg;
  logic [OUT_W-1:0] outdiv_reg;
  logic [1:0] prediv_reg;
  logic [2:0] fratio_reg;
  logic [15:0] numer_reg;
  logic [15:0] denom_reg;
  logic [N_W-1:0] intmul_reg;
  logic [1:0] refsrc_reg;
  run_state_t state_reg;
  run_state_t state_next;
  logic sel_level;
  logic sel_prev_reg;
  logic ref_edge;
  logic run_out;
  logic cfg_bad;
  logic [15:0] read_value;

  // Address match used by every register write process
  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction : hit

  // ----------------------------------------
  // Control one: enable and mode
  // ----------------------------------------
  // Enable and mode are live; the loop picks them up at once
  always_ff @(posedge clk) begin
    if (reset) begin
      ena_reg <= `RST_ENA;
      frac_reg <= `RST_FRAC;
    end else if (bus.wr && hit(bus.addr, `OFF_CTRL_ONE)) begin
      ena_reg <= bus.wdata[`ENA_BIT];
      frac_reg <= bus.wdata[`FRAC_BIT];
    end
  end

  // ----------------------------------------
  // Control two and three: dividers
  // ----------------------------------------
  // Dividers are not locked while running; software stops the loop
  // first, otherwise the loop sees a step in frequency
  always_ff @(posedge clk) begin
    if (reset) begin
      outdiv_reg <= `RST_OUTDIV;
      prediv_reg <= `RST_PREDIV;
    end else if (bus.wr && hit(bus.addr, `OFF_DIV_CTRL)) begin
      outdiv_reg <= bus.wdata[`OUTDIV_MSB:`OUTDIV_LSB];
      prediv_reg <= bus.wdata[`PREDIV_MSB:0];
    end
  end

  // VCO ratio code
  always_ff @(posedge clk) begin
    if (reset) begin
      fratio_reg <= `RST_FRATIO;
    end else if (bus.wr && hit(bus.addr, `OFF_RATIO_CTRL)) begin
      fratio_reg <= bus.wdata[`FRATIO_MSB:0];
    end
  end

  // ----------------------------------------
  // Multiplier fields
  // ----------------------------------------
  // Plain unsigned values, stored as written
  always_ff @(posedge clk) begin
    if (reset) begin
      numer_reg <= `RST_NUMER;
      denom_reg <= `RST_DENOM;
      intmul_reg <= `RST_INTMUL;
    end else if (bus.wr) begin
      if (hit(bus.addr, `OFF_NUMER)) begin
        numer_reg <= bus.wdata;
      end
      if (hit(bus.addr, `OFF_DENOM)) begin
        denom_reg <= bus.wdata;
      end
      if (hit(bus.addr, `OFF_INTMUL)) begin
        intmul_reg <= bus.wdata[N_W-1:0];
      end
    end
  end

  // ----------------------------------------
  // Reference selection
  // ----------------------------------------
  // Source code write
  always_ff @(posedge clk) begin
    if (reset) begin
      refsrc_reg <= `RST_REF_SRC;
    end else if (bus.wr && hit(bus.addr, `OFF_REF_SRC)) begin
      refsrc_reg <= bus.wdata[1:0];
    end
  end

  // Source mux; unused code 3 selects the oscillator
  always_comb begin
    case (refsrc_reg)
      SRC_MASTER: sel_level = master_clk_in;
      SRC_BIT: sel_level = bit_clk_in;
      default: sel_level = osc_clk_in;
    endcase
  end

  // Switching source while enabled may give one stray edge; that is
  // why the loop is to be reset around a reference change
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_level;
    end
  end

  assign ref_edge = sel_level && !sel_prev_reg;

  // Reference pre-divider
  ref_prediv u_prediv (
    .clk(clk),
    .reset(reset),
    .run(ena_reg),
    .ref_edge(ref_edge),
    .code(prediv_reg),
    .tick(ref_tick)
  );

  // ----------------------------------------
  // Enable sequencing
  // ----------------------------------------
  // The output divider starts on the first divided reference tick,
  // so the loop has a reference before any clock edge leaves
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_OFF: begin
        if (ena_reg) begin
          state_next = ST_ARM;
        end
      end
      ST_ARM: begin
        if (!ena_reg) begin
          state_next = ST_OFF;
        end else if (ref_tick) begin
          state_next = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!ena_reg) begin
          state_next = ST_OFF;
        end
      end
      default: state_next = ST_OFF;
    endcase
  end

  // State register
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= ST_OFF;
    end else begin
      state_reg <= state_next;
    end
  end

  assign run_out = (state_reg == ST_RUN);

  // Output divider
  out_divider #(
    .W(OUT_W)
  ) u_outdiv (
    .clk(clk),
    .reset(reset),
    .run(run_out),
    .vco_tick(vco_tick),
    .code(outdiv_reg),
    .clk_out(system_clock)
  );

  // ----------------------------------------
  // Settings to the analogue loop
  // ----------------------------------------
  // In integer mode the numerator is forced to zero so that K drops
  // out; the denominator still goes over and must stay non-zero
  always_ff @(posedge clk) begin
    if (reset) begin
      loop_cfg <= '0;
    end else begin
      loop_cfg.enable <= ena_reg;
      loop_cfg.fractional <= frac_reg;
      loop_cfg.n <= intmul_reg;
      loop_cfg.theta <= frac_reg ? numer_reg : 16'h0000;
      loop_cfg.lambda <= denom_reg;
      loop_cfg.vco_mult <= decode_vco_ratio(fratio_reg);
    end
  end

  // Settings the loop cannot use; shown to software only
  assign cfg_bad = (denom_reg == 16'h0000) ||
                   (frac_reg && (numer_reg >= denom_reg));

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  // Reserved fields read back at their fixed values
  always_comb begin
    read_value = 16'h0000;
    case (bus.addr)
      `OFF_CTRL_ONE: begin
        read_value[`ENA_BIT] = ena_reg;
        read_value[`FRAC_BIT] = frac_reg;
        read_value[`RSV1_BIT] = `RST_RSV1;
      end
      `OFF_DIV_CTRL: begin
        read_value[`OUTDIV_MSB:`OUTDIV_LSB] = outdiv_reg;
        read_value[`PREDIV_MSB:0] = prediv_reg;
      end
      `OFF_RATIO_CTRL: begin
        read_value[`RSV3_MSB:`RSV3_LSB] = `RST_RSV3;
        read_value[`FRATIO_MSB:0] = fratio_reg;
      end
      `OFF_RSVD_CTRL: read_value[`RSV4_MSB:0] = `RST_RSV4;
      `OFF_NUMER: read_value = numer_reg;
      `OFF_DENOM: read_value = denom_reg;
      `OFF_INTMUL: read_value[N_W-1:0] = intmul_reg;
      `OFF_REF_SRC: read_value[1:0] = refsrc_reg;
      `OFF_STATUS: begin
        read_value[0] = run_out;
        read_value[1] = (state_reg == ST_ARM);
        read_value[2] = cfg_bad;
      end
      default: read_value = 16'h0000;
    endcase
  end

  // Data stand for one cycle only; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= bus.rd ? read_value : 16'h0000;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence loop_off_s;
    !ena_reg [*3];
  endsequence

  sequence arm_tick_s;
    (state_reg == ST_ARM) && ena_reg && ref_tick;
  endsequence

  src_master_a: assert property (
    $rose(master_clk_in) && $stable(refsrc_reg) &&
    (refsrc_reg == 2'b00) |-> ref_edge)
    else $error("master clock edge not taken");

  prediv_one_a: assert property (
    ena_reg && $past(ena_reg) && (prediv_reg == 2'h0) &&
    $stable(prediv_reg) && ref_edge |=> ref_tick)
    else $error("divide by one missed a tick");

  int_mode_a: assert property (
    !frac_reg |=> (loop_cfg.theta == 16'h0000))
    else $error("fraction passed in integer mode");

  frac_pass_a: assert property (
    frac_reg |=> (loop_cfg.theta == $past(numer_reg)) &&
    (loop_cfg.n == $past(intmul_reg)))
    else $error("multiplier fields not passed on");

  vco_top_a: assert property (
    fratio_reg[2] |=> (loop_cfg.vco_mult == 5'h10))
    else $error("VCO ratio with top bit not sixteen");

  reset_vals_a: assert property (
    $past(reset) |-> (numer_reg == 16'h0018) &&
    (denom_reg == 16'h007D) && (intmul_reg == 10'h008) &&
    (prediv_reg == 2'h1) && frac_reg && !ena_reg)
    else $error("wrong value after reset");

  rsv_read_a: assert property (
    bus.rd && (bus.addr == `OFF_RATIO_CTRL) |=>
    (rdata[8:4] == 5'h18))
    else $error("reserved field read wrong");

  enable_write_a: assert property (
    bus.wr && (bus.addr == `OFF_CTRL_ONE) |=>
    (ena_reg == $past(bus.wdata[0])) ##1 (loop_cfg.enable == $past(ena_reg)))
    else $error("enable bit not taken");

  clock_off_a: assert property (
    loop_off_s |-> !system_clock)
    else $error("system clock runs while disabled");

  clean_start_a: assert property (
    arm_tick_s |=> run_out ##0 !system_clock)
    else $error("output did not start from low");

endmodule : fll_clock_synthesis_control

/* File: verification/testbench.sv */
`timescale 1ns/1ps

module testbench;
  import fll_pkg::*;

  // --------------------------------------------------------------
  // Signals, clock and instance
  // --------------------------------------------------------------
  typedef struct {
    logic [7:0] a;
    logic w;
    logic [15:0] d;
    logic [15:0] e;
  } row_t;

  logic clk = 1'b0;
  logic reset = 1'b1;
  bus_req_t bus = '0;
  logic [2:0] refs = 3'h0;
  logic vco_tick = 1'b0;
  logic [15:0] rdata;
  loop_cfg_t cfg;
  logic ref_tick;
  logic system_clock;
  logic sc_prev = 1'b0;
  int fails = 0;
  int comparisons = 0;
  int cyc = 0;
  int ticks = 0;
  int rises = 0;
  int highs = 0;
  int t0;
  int r0;
  int h0;
  int div_of[4] = '{1, 2, 4, 4};
  int codes[4] = '{1, 2, 7, 63};
  row_t rows[19] = '{
    '{8'h9B, 1'b0, 16'h0000, 16'h000C}, '{8'h9C, 1'b0, 16'h0000, 16'h0039},
    '{8'h9D, 1'b0, 16'h0000, 16'h0180}, '{8'h9E, 1'b0, 16'h0000, 16'h0000},
    '{8'hA0, 1'b0, 16'h0000, 16'h0018}, '{8'hA1, 1'b0, 16'h0000, 16'h007D},
    '{8'hA2, 1'b0, 16'h0000, 16'h0008}, '{8'hA3, 1'b0, 16'h0000, 16'h0000},
    '{8'h50, 1'b0, 16'h0000, 16'h0000}, '{8'h9B, 1'b1, 16'hFFFB, 16'h0009},
    '{8'h9B, 1'b1, 16'h0004, 16'h000C}, '{8'h9C, 1'b1, 16'hFFFF, 16'h01FB},
    '{8'h9D, 1'b1, 16'hFFFF, 16'h0187}, '{8'h9E, 1'b1, 16'hFFFF, 16'h0000},
    '{8'hA0, 1'b1, 16'h1234, 16'h1234}, '{8'hA1, 1'b1, 16'hABCD, 16'hABCD},
    '{8'hA2, 1'b1, 16'hFFFF, 16'h03FF}, '{8'hA3, 1'b1, 16'hFFFF, 16'h0003},
    '{8'h50, 1'b1, 16'hFFFF, 16'h0000}};

  // Free-running 25 MHz clock
  always #20 clk = ~clk;

  fll_clock_synthesis_control #(.OUT_W(6), .N_W(10))
    u_fll_clock_synthesis_control (
    .clk(clk),
    .reset(reset),
    .bus(bus),
    .master_clk_in(refs[0]),
    .bit_clk_in(refs[1]),
    .osc_clk_in(refs[2]),
    .vco_tick(vco_tick),
    .rdata(rdata),
    .loop_cfg(cfg),
    .ref_tick(ref_tick),
    .system_clock(system_clock)
  );

  // Running counts; tests compare differences so no counter reset
  always @(posedge clk) begin
    cyc <= cyc + 1;
    sc_prev <= system_clock;
    ticks <= ticks + int'(ref_tick === 1'b1);
    rises <= rises + int'(system_clock === 1'b1 && sc_prev === 1'b0);
    highs <= highs + int'(system_clock === 1'b1);
    if (cyc == 20000) begin
      fails++;
      test_done();
    end
  end

  // --------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------
  // Wide enough for the whole settings struct, enable bit included
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // One-cycle write strobe, then an idle cycle so strobes never merge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus <= '0;
    @(posedge clk);
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(48'(rdata), 48'(e));
    @(posedge clk);
  endtask : rd

  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask : settle

  task automatic ref_edges(input int idx, input int n);
    repeat (n) begin
      refs[idx] <= 1'b1;
      repeat (2) @(posedge clk);
      refs[idx] <= 1'b0;
      repeat (2) @(posedge clk);
    end
  endtask : ref_edges

  task automatic vco(input int n);
    repeat (n) begin
      vco_tick <= 1'b1;
      @(posedge clk);
      vco_tick <= 1'b0;
      @(posedge clk);
    end
  endtask : vco

  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : test_done

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(48'({rdata, ref_tick, system_clock}), 48'h0);
    settle();
    chk(64'(cfg), 64'({1'b0, 1'b1, 10'h008, 16'h0018, 16'h007D, 5'h01}));
    $display("test reset done");
    // Table rows: reset values, write masks, fixed and unmapped places
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end
      rd(rows[i].a, rows[i].e);
    end
    $display("test register table done");
    // Every ratio code, top bit set meaning sixteen
    for (int c = 0; c < 8; c++) begin
      wr(8'h9D, 16'(c));
      settle();
      chk(48'(cfg.vco_mult), 48'(c > 3 ? 16 : 1 << c));
    end
    $display("test vco ratio done");
    // Integer mode drops the fraction but keeps N
    wr(8'h9B, 16'h0000);
    settle();
    chk(48'({cfg.fractional, cfg.theta, cfg.n}), 48'({1'b0, 16'h0, 10'h3FF}));
    wr(8'h9B, 16'h0004);
    settle();
    chk(48'({cfg.fractional, cfg.theta}), 48'({1'b1, 16'h1234}));
    $display("test fraction mode done");
    // Each source with its own pre-divide; other inputs stay idle
    for (int i = 0; i < 4; i++) begin
      wr(8'h9B, 16'h0004);
      wr(8'hA3, 16'(i));
      wr(8'h9C, 16'h0038 | 16'(i));
      wr(8'h9B, 16'h0005);
      settle();
      chk(48'(cfg.enable), 48'h1);
      // Enabled with no reference edge yet: armed, settings sound
      rd(8'hA4, 16'h0002);
      t0 = ticks;
      ref_edges(i == 3 ? 2 : i, 16);
      repeat (3) @(posedge clk);
      chk(48'(ticks - t0), 48'(16 / div_of[i]));
    end
    $display("test reference path done");
    // Output ratio: eight whole periods, each with its high share
    foreach (codes[k]) begin
      wr(8'h9B, 16'h0004);
      wr(8'hA3, 16'h0000);
      wr(8'h9C, 16'(codes[k] << 3));
      wr(8'h9B, 16'h0005);
      ref_edges(0, 2);
      repeat (2) @(posedge clk);
      r0 = rises;
      h0 = highs;
      vco(8 * (codes[k] + 1));
      repeat (4) @(posedge clk);
      chk(48'(rises - r0), 48'h8);
      chk(48'(highs - h0), 48'(16 * ((codes[k] + 1) / 2)));
    end
    // Disabled loop keeps the output low whatever the VCO does
    wr(8'h9B, 16'h0004);
    settle();
    h0 = highs;
    vco(10);
    #1;
    chk(48'({highs - h0, system_clock}), 48'h0);
    $display("test output divider done");
    // Second reset in mid-run restores defaults
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk(48'(system_clock), 48'h0);
    rd(8'hA0, 16'h0018);
    rd(8'h9C, 16'h0039);
    $display("test second reset done");
    test_done();
  end
endmodule : testbench
